/* include/hscfg_defs.svh */
// Overview of operation
// - 16-bit user revision word, read/write
// - Silicon revision readable at own code and 9Bh
// - Config bit 15 ignores writes, reads zero
// - Bit 14: over-temperature hiccup 0, latch-off 1
// - Bit 13: max soft-start hiccup 0, latch-off 1
// - Bit 11 enables follower soft-start fault detect
// - Bit 10 pulls soft-start low on fault
// - Bit 9: direct format 0, linear 1
// - Linear exponent auto-picked, finest fitting resolution
// - Voltage steps 31.25mV or 62.5mV, to 64V
// - Current steps 0.0625A to 1A, to 1023A
// - Power steps 1W to 64W, to 65.535kW
// - Linear word: exponent 15:11, mantissa 10:0
// - Direct voltage: upper five zero, 31.25mV counts
`ifndef HSCFG_DEFS_SVH
`define HSCFG_DEFS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define HSCFG_CMD_USER_REV   8'hc2
`define HSCFG_CMD_SI_REV     8'hc3
`define HSCFG_CMD_REV_ALIAS  8'h9b
`define HSCFG_CMD_FUNC_CFG   8'hc4

// ----------------------------------------------------------------
// Function configuration fields
// ----------------------------------------------------------------
`define HSCFG_BIT_RSVD15     15
`define HSCFG_BIT_OTP_LATCH  14
`define HSCFG_BIT_MSS_LATCH  13
`define HSCFG_BIT_RSVD12     12
`define HSCFG_BIT_FOLLOW_EN  11
`define HSCFG_BIT_SS_PULL    10
`define HSCFG_BIT_LINEAR     9
`define HSCFG_FUNC_WR_MASK   16'h7fc0
`define HSCFG_FUNC_FIXED     16'h0008

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSCFG_USER_REV_RST   16'h0000
`define HSCFG_FUNC_CFG_RST   16'h0008

// ----------------------------------------------------------------
// Linear format
// ----------------------------------------------------------------
`define HSCFG_MANT_MAX       10'h3ff
`define HSCFG_V_BASE_EXP     (-5)
`define HSCFG_V_MAX_SHIFT    1
`define HSCFG_I_BASE_EXP     (-4)
`define HSCFG_I_MAX_SHIFT    4
`define HSCFG_P_BASE_EXP     0
`define HSCFG_P_MAX_SHIFT    6

`endif

/* include/hscfg_pkg.sv */
`default_nettype none

package hscfg_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } hscfg_cmd_type;

  typedef struct packed {
    logic enable;
    logic on;
    logic power_good_pin;
    logic soft_start;
  } hscfg_pins_type;

  typedef struct packed {
    logic otp_latch;
    logic max_ss_latch;
    logic report_format_select;
  } hscfg_mode_type;

endpackage

`default_nettype wire

/* rtl/hscfg_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hscfg_defs.svh"

module hscfg_fmt
  import hscfg_pkg::*;
#(
  parameter int RAW_W     = 16,
  parameter int BASE_EXP  = 0,
  parameter int MAX_SHIFT = 6
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             linear_i,
  input  wire logic [RAW_W-1:0] raw_i,
  output logic      [15:0]      report_o
);

  if (RAW_W < 11 || RAW_W > 16 || MAX_SHIFT < 0 || MAX_SHIFT > 15 ||
      BASE_EXP < -16 || BASE_EXP + MAX_SHIFT > 15) begin : g_chk
    $error("hscfg_fmt: unsupported parameters");
  end

  // Smallest shift whose mantissa still fits a positive 11-bit value
  function automatic logic [4:0] fit_shift(input logic [RAW_W-1:0] v);
    logic [4:0] s;
    s = 5'(MAX_SHIFT);
    for (int k = MAX_SHIFT; k >= 0; k--) begin
      if ((v >> k) <= RAW_W'(`HSCFG_MANT_MAX)) begin
        s = 5'(k);
      end
    end
    return s;
  endfunction

  logic [4:0]       shift_w;
  logic [RAW_W-1:0] shifted_w;
  logic [9:0]       mant_w;
  logic [15:0]      report_d;

  always_comb begin
    shift_w   = fit_shift(raw_i);
    shifted_w = raw_i >> shift_w;
    // Saturate rather than wrap above full scale
    if (shifted_w > RAW_W'(`HSCFG_MANT_MAX)) begin
      mant_w = `HSCFG_MANT_MAX;
    end else begin
      mant_w = shifted_w[9:0];
    end
    if (linear_i) begin
      report_d = {5'(BASE_EXP + int'(shift_w)), 1'b0, mant_w};
    end else begin
      report_d = 16'(raw_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      report_o <= 16'h0000;
    end else begin
      report_o <= report_d;
    end
  end

  logic [4:0] sh_chk;
  assign sh_chk = report_o[15:11] - 5'(BASE_EXP);

  chk_fmt_direct: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !linear_i |=> report_o == 16'($past(raw_i)))
    else $error("direct report differs from raw value");

  chk_fmt_linear: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    linear_i |=> report_o[10] == 1'b0 &&
      int'(sh_chk) <= MAX_SHIFT &&
      (sh_chk == 5'h00 || ($past(raw_i) >> (sh_chk - 5'h01)) >
        RAW_W'(`HSCFG_MANT_MAX)) &&
      (int'(sh_chk) == MAX_SHIFT ||
        ($past(raw_i) >> sh_chk) == RAW_W'(report_o[9:0])))
    else $error("linear report not finest fitting exponent");

endmodule
`default_nettype wire

/* rtl/hscfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hscfg_defs.svh"

module hscfg_top
  import hscfg_pkg::*;
#(
  // Arbitrary value, replaced by trimmed silicon revision
  parameter logic [7:0] SILICON_REV_RST = 8'h00
) (
  input  wire logic           ref_clk_i,
  input  wire logic           arst_n_i,
  input  wire hscfg_cmd_type  cmd_i,
  input  wire hscfg_pins_type pins_i,
  input  wire logic           fault_i,
  input  wire logic [10:0]    vout_raw_i,
  input  wire logic [13:0]    iout_raw_i,
  input  wire logic [15:0]    pout_raw_i,
  output logic      [15:0]    rd_data_o,
  output logic                rd_valid_o,
  output logic                cmd_unsup_o,
  output hscfg_mode_type      mode_o,
  output logic                follower_fault_o,
  output logic                soft_start_o,
  output logic                soft_start_oe_o,
  output logic      [15:0]    vout_report_o,
  output logic      [15:0]    iout_report_o,
  output logic      [15:0]    pout_report_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] user_product_revision_q;
  logic [7:0]  silicon_revision_store_q;
  logic [15:0] function_configuration_q;
  logic [15:0] func_rd_w;

  // Writes store only writable bits; fixed bits are forced on read
  assign func_rd_w = (function_configuration_q & `HSCFG_FUNC_WR_MASK) |
                     `HSCFG_FUNC_FIXED;

  function automatic logic is_cmd(input hscfg_cmd_type c,
                                  input logic [7:0]    code);
    return c.code == code;
  endfunction

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      user_product_revision_q <= `HSCFG_USER_REV_RST;
    end else if (cmd_i.wr && is_cmd(cmd_i, `HSCFG_CMD_USER_REV)) begin
      user_product_revision_q <= cmd_i.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      silicon_revision_store_q <= SILICON_REV_RST;
    end else if (cmd_i.wr && is_cmd(cmd_i, `HSCFG_CMD_SI_REV)) begin
      silicon_revision_store_q <= cmd_i.data[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      function_configuration_q <= `HSCFG_FUNC_CFG_RST;
    end else if (cmd_i.wr && is_cmd(cmd_i, `HSCFG_CMD_FUNC_CFG)) begin
      // Bit 12 is stored as written; host keeps it zero
      function_configuration_q <= cmd_i.data & `HSCFG_FUNC_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rd_data_d;
  logic        known_w;
  logic        read_only_w;

  always_comb begin
    rd_data_d   = 16'h0000;
    known_w     = 1'b1;
    read_only_w = 1'b0;
    case (cmd_i.code)
      `HSCFG_CMD_USER_REV:  rd_data_d = user_product_revision_q;
      `HSCFG_CMD_SI_REV:    rd_data_d = 16'(silicon_revision_store_q);
      `HSCFG_CMD_REV_ALIAS: begin
        rd_data_d   = 16'(silicon_revision_store_q);
        read_only_w = 1'b1;
      end
      `HSCFG_CMD_FUNC_CFG:  rd_data_d = func_rd_w;
      default:              known_w   = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o  <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= cmd_i.rd && !cmd_i.wr;
      if (cmd_i.rd && !cmd_i.wr) begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  // Unknown code, or write to the read-only alias, flags one cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_unsup_o <= 1'b0;
    end else begin
      cmd_unsup_o <= (cmd_i.rd || cmd_i.wr) &&
                     (!known_w || (cmd_i.wr && read_only_w));
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs and soft-start pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_o <= '0;
    end else begin
      mode_o.otp_latch    <=
        function_configuration_q[`HSCFG_BIT_OTP_LATCH];
      mode_o.max_ss_latch <=
        function_configuration_q[`HSCFG_BIT_MSS_LATCH];
      mode_o.report_format_select <=
        function_configuration_q[`HSCFG_BIT_LINEAR];
    end
  end

  logic follower_fault_detect_enable;
  logic soft_start_pull_en;
  assign follower_fault_detect_enable =
    function_configuration_q[`HSCFG_BIT_FOLLOW_EN];
  assign soft_start_pull_en = function_configuration_q[`HSCFG_BIT_SS_PULL];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      follower_fault_o <= 1'b0;
    end else begin
      follower_fault_o <= follower_fault_detect_enable && pins_i.enable &&
                          pins_i.on && pins_i.power_good_pin &&
                          !pins_i.soft_start;
    end
  end

  // Open-drain: only ever drives low
  assign soft_start_o = 1'b0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_start_oe_o <= 1'b0;
    end else begin
      soft_start_oe_o <= soft_start_pull_en && fault_i;
    end
  end

  // ----------------------------------------------------------------
  // Telemetry formatting
  // ----------------------------------------------------------------
  logic linear_w;
  assign linear_w = function_configuration_q[`HSCFG_BIT_LINEAR];

  hscfg_fmt #(
    .RAW_W     (11),
    .BASE_EXP  (`HSCFG_V_BASE_EXP),
    .MAX_SHIFT (`HSCFG_V_MAX_SHIFT)
  ) u_fmt_v (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .linear_i  (linear_w),
    .raw_i     (vout_raw_i),
    .report_o  (vout_report_o)
  );

  hscfg_fmt #(
    .RAW_W     (14),
    .BASE_EXP  (`HSCFG_I_BASE_EXP),
    .MAX_SHIFT (`HSCFG_I_MAX_SHIFT)
  ) u_fmt_i (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .linear_i  (linear_w),
    .raw_i     (iout_raw_i),
    .report_o  (iout_report_o)
  );

  hscfg_fmt #(
    .RAW_W     (16),
    .BASE_EXP  (`HSCFG_P_BASE_EXP),
    .MAX_SHIFT (`HSCFG_P_MAX_SHIFT)
  ) u_fmt_p (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .linear_i  (linear_w),
    .raw_i     (pout_raw_i),
    .report_o  (pout_report_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_user_rev_rw: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == `HSCFG_CMD_USER_REV) ##1
    (cmd_i.rd && !cmd_i.wr && cmd_i.code == `HSCFG_CMD_USER_REV)
    |=> rd_valid_o && rd_data_o == $past(cmd_i.data, 2))
    else $error("user revision read-back mismatch");

  chk_rev_alias: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && !cmd_i.wr && cmd_i.code == `HSCFG_CMD_REV_ALIAS)
    |=> rd_valid_o && rd_data_o == 16'($past(silicon_revision_store_q)))
    else $error("revision alias read mismatch");

  chk_rsvd15_zero: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && !cmd_i.wr && cmd_i.code == `HSCFG_CMD_FUNC_CFG)
    |=> rd_valid_o && rd_data_o[`HSCFG_BIT_RSVD15] == 1'b0)
    else $error("reserved bit 15 read as one");

  chk_otp_mode: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == `HSCFG_CMD_FUNC_CFG)
    |=> ##1 mode_o.otp_latch == $past(cmd_i.data[14], 2))
    else $error("over-temperature mode not taken from bit 14");

  chk_max_ss_mode: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == `HSCFG_CMD_FUNC_CFG)
    |=> ##1 mode_o.max_ss_latch == $past(cmd_i.data[13], 2))
    else $error("max soft-start mode not taken from bit 13");

  chk_follower_flt: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (pins_i.enable && pins_i.on && pins_i.power_good_pin &&
     !pins_i.soft_start) |=>
    follower_fault_o == $past(follower_fault_detect_enable))
    else $error("follower fault flag wrong");

  chk_ss_pull: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    fault_i |=> soft_start_oe_o == $past(soft_start_pull_en) &&
                soft_start_o == 1'b0)
    else $error("soft-start pull-down wrong on fault");

  chk_follower_idle: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !(pins_i.enable && pins_i.on && pins_i.power_good_pin &&
      !pins_i.soft_start) |=> !follower_fault_o)
    else $error("follower fault flag set without pin condition");

  chk_ss_idle: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !fault_i |=> !soft_start_oe_o)
    else $error("soft-start pulled low without a fault");

  chk_format_sel: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !linear_w ##1 !linear_w |-> vout_report_o[15:11] == 5'h00)
    else $error("direct voltage report has nonzero upper bits");

endmodule
`default_nettype wire

/* tb/hscfg_host.sv */
`timescale 1ns/1ps
`default_nettype none

module hscfg_host
  import hscfg_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic [15:0]   rd_data_i,
  input  wire logic          rd_valid_i,
  input  wire logic          unsup_i,
  output var  hscfg_cmd_type cmd_o
);
  logic [15:0] last_data;
  logic        last_valid;
  logic        last_unsup;

  initial cmd_o = '0;

  // ------------------------------------------------------------
  // Command tasks
  // ------------------------------------------------------------
  // Leaves the write raised, so the next task may follow back to back
  task automatic write(input logic [7:0] code, input logic [15:0] data);
    @(posedge ref_clk_i);
    cmd_o <= '{wr: 1'b1, rd: 1'b0, code: code,
               data: (code == 8'hc4) ? (data & 16'hefff) : data};
  endtask

  // Drops the request, then samples the one-cycle answers
  task automatic idle();
    @(posedge ref_clk_i);
    cmd_o <= '0;
    #1;
    last_data  = rd_data_i;
    last_valid = rd_valid_i;
    last_unsup = unsup_i;
  endtask

  task automatic read(input logic [7:0] code);
    @(posedge ref_clk_i);
    cmd_o <= '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h0000};
    idle();
  endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import hscfg_pkg::*;

  typedef struct {
    logic [7:0]  wc;
    logic [15:0] wd;
    logic [7:0]  rc;
    logic [15:0] exp;
  } hscfg_row_type;

  logic           ref_clk_i = 1'b0;
  logic           arst_n_i  = 1'b0;
  hscfg_cmd_type  cmd;
  hscfg_pins_type pins_i    = '0;
  logic           fault_i   = 1'b0;
  logic [10:0]    vout_raw  = '0;
  logic [13:0]    iout_raw  = '0;
  logic [15:0]    pout_raw  = '0;
  logic [15:0]    rd_data, vrep, irep, prep;
  logic           rd_valid, unsup, ffault, ss_o, ss_oe;
  hscfg_mode_type mode;
  int             fail_count   = 0;
  int             total_checks = 0;

  hscfg_row_type rows [9] = '{
    '{8'hc2, 16'h1234, 8'hc2, 16'h1234},
    '{8'hc2, 16'hedcb, 8'hc2, 16'hedcb},
    '{8'hc3, 16'hffa5, 8'hc3, 16'h00a5},
    '{8'h9b, 16'h0055, 8'h9b, 16'h00a5},
    '{8'hc4, 16'hffff, 8'hc4, 16'h6fc8},
    '{8'hc4, 16'h4000, 8'hc4, 16'h4008},
    '{8'hc4, 16'h2000, 8'hc4, 16'h2008},
    '{8'hc4, 16'h0200, 8'hc4, 16'h0208},
    '{8'hc4, 16'h0000, 8'hc4, 16'h0008}};

  always #20 ref_clk_i = ~ref_clk_i;

  hscfg_host host (
    .ref_clk_i  (ref_clk_i),
    .rd_data_i  (rd_data),
    .rd_valid_i (rd_valid),
    .unsup_i    (unsup),
    .cmd_o      (cmd)
  );

  hscfg_top uut (
    .ref_clk_i        (ref_clk_i),
    .arst_n_i         (arst_n_i),
    .cmd_i            (cmd),
    .pins_i           (pins_i),
    .fault_i          (fault_i),
    .vout_raw_i       (vout_raw),
    .iout_raw_i       (iout_raw),
    .pout_raw_i       (pout_raw),
    .rd_data_o        (rd_data),
    .rd_valid_o       (rd_valid),
    .cmd_unsup_o      (unsup),
    .mode_o           (mode),
    .follower_fault_o (ffault),
    .soft_start_o     (ss_o),
    .soft_start_oe_o  (ss_oe),
    .vout_report_o    (vrep),
    .iout_report_o    (irep),
    .pout_report_o    (prep)
  );

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Pins and fault are registered once inside, so one edge later
  task automatic drive_pins(input logic [3:0] p, input logic f);
    @(posedge ref_clk_i);
    pins_i  <= p;
    fault_i <= f;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic tele(input logic [10:0] v, input logic [13:0] i,
                      input logic [15:0] p, input logic [15:0] ev,
                      input logic [15:0] ei, input logic [15:0] ep);
    @(posedge ref_clk_i);
    vout_raw <= v;
    iout_raw <= i;
    pout_raw <= p;
    @(posedge ref_clk_i);
    #1;
    chk("vout_report", vrep, ev);
    chk("iout_report", irep, ei);
    chk("pout_report", prep, ep);
  endtask

  task automatic cfg(input logic [15:0] d);
    host.write(8'hc4, d);
    host.idle();
  endtask

  initial begin
    #40000;
    fail_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      host.write(rows[i].wc, rows[i].wd);
      host.read(rows[i].rc);
      chk("rd_data", host.last_data, rows[i].exp);
      chk("rd_valid", {15'h0, host.last_valid}, 16'h0001);
      if (rows[i].rc == 8'hc4) begin
        chk("mode", {13'h0, mode}, {13'h0, rows[i].exp[14],
            rows[i].exp[13], rows[i].exp[9]});
      end
    end
    // Reset in mid-run after registers were changed
    host.write(8'hc2, 16'h5a5a);
    host.write(8'hc4, 16'h6e00);
    host.idle();
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    #1;
    chk("mode_rst", {13'h0, mode}, 16'h0000);
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    host.read(8'hc2);
    chk("user_rev_rst", host.last_data, 16'h0000);
    host.read(8'hc4);
    chk("func_cfg_rst", host.last_data, 16'h0008);
    host.read(8'hc3);
    chk("si_rev_rst", host.last_data, 16'h0000);
    // Alias code is read-only, unknown codes read zero
    host.write(8'h9b, 16'h0001);
    host.idle();
    chk("unsup_wr", {15'h0, host.last_unsup}, 16'h0001);
    host.read(8'h00);
    chk("unknown_rd", host.last_data, 16'h0000);
    // Follower fault detect
    cfg(16'h0800);
    drive_pins(4'b1110, 1'b0);
    chk("follower_on", {15'h0, ffault}, 16'h0001);
    drive_pins(4'b1111, 1'b0);
    chk("follower_ss_hi", {15'h0, ffault}, 16'h0000);
    drive_pins(4'b0110, 1'b0);
    chk("follower_no_en", {15'h0, ffault}, 16'h0000);
    cfg(16'h0000);
    drive_pins(4'b1110, 1'b0);
    chk("follower_off", {15'h0, ffault}, 16'h0000);
    // Soft-start pull-down on fault
    cfg(16'h0400);
    drive_pins(4'b0000, 1'b1);
    chk("ss_pull", {14'h0, ss_oe, ss_o}, 16'h0002);
    drive_pins(4'b0000, 1'b0);
    chk("ss_release", {14'h0, ss_oe, ss_o}, 16'h0000);
    cfg(16'h0000);
    drive_pins(4'b0000, 1'b1);
    chk("ss_no_pull", {14'h0, ss_oe, ss_o}, 16'h0000);
    // Telemetry, direct then linear
    tele(11'h7ff, 14'h3fff, 16'hffff,
         16'h07ff, 16'h3fff, 16'hffff);
    cfg(16'h0200);
    @(posedge ref_clk_i);
    tele(11'h7ff, 14'h3fff, 16'hffff,
         16'he3ff, 16'h03ff, 16'h33ff);
    tele(11'h100, 14'h0800, 16'h0003,
         16'hd900, 16'hf200, 16'h0003);
    close_out();
  end
endmodule

`default_nettype wire
